//--- afe_regs_pkg.sv
// Constants, field layouts and types of the front-end register block.
// Assumes one 250 MHz clock; all SPI pins already synchronous to it.

package afe_regs_pkg;

    // ========================================
    // Register offsets
    localparam logic [6:0] OFF_CURRENT_MONITOR = 7'h02;
    localparam logic [6:0] OFF_GATE_DRIVER     = 7'h03;
    localparam logic [6:0] OFF_CHARGER_DETECT  = 7'h04;

    // ========================================
    // Reset values
    localparam logic [7:0] RST_CURRENT_MONITOR = 8'h00;
    localparam logic [7:0] RST_GATE_DRIVER     = 8'h00;
    localparam logic [7:0] RST_CHARGER_DETECT  = 8'h00;

    // ========================================
    // Current monitor control fields
    localparam int GAIN_SELECT_BIT     = 0;
    localparam int ZERO_CAL_BIT        = 1;
    localparam int GAIN_CAL_INPUT_BIT  = 2;
    localparam int GAIN_CAL_OUTPUT_BIT = 3;
    localparam int MONITOR_ENABLE_BIT  = 4;
    localparam int MONITOR_FIELD_W     = 5;

    // ========================================
    // Gate driver control fields
    localparam int DISCHARGE_GATE_BIT = 0;
    localparam int CHARGE_GATE_BIT    = 1;
    localparam int DRIVE_BOOST_BIT    = 4;

    // ========================================
    // Charger detect control fields
    localparam int LOW_STATUS_BIT      = 0;
    localparam int LOW_FLAG_BIT        = 1;
    localparam int LOW_IRQ_ENABLE_BIT  = 2;
    localparam int LOW_RUN_BIT         = 3;
    localparam int HIGH_STATUS_BIT     = 4;
    localparam int HIGH_FLAG_BIT       = 5;
    localparam int HIGH_IRQ_ENABLE_BIT = 6;
    localparam int HIGH_RUN_BIT        = 7;

    // ========================================
    // Serial frame
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ========================================
    // Analog steering codes
    localparam logic [1:0] POS_FROM_PIN   = 2'h0;
    localparam logic [1:0] POS_GROUND     = 2'h1;
    localparam logic [1:0] POS_REF_100MV  = 2'h2;
    localparam logic [1:0] POS_REF_20MV   = 2'h3;
    localparam logic [1:0] MON_ZERO_VOLT  = 2'h0;
    localparam logic [1:0] MON_AMPLIFIED  = 2'h1;
    localparam logic [1:0] MON_REFERENCE  = 2'h2;

    typedef enum logic [1:0] {
        SPI_IDLE,
        SPI_ADDR,
        SPI_DATA,
        SPI_DONE
    } spi_state_t;

    typedef struct packed {
        spi_state_t                  spi_state;
        logic                        sck_q;
        logic [2:0]                  bit_cnt;
        logic [7:0]                  shift;
        logic [7:0]                  tx;
        logic                        rw;
        logic [6:0]                  addr;
        logic                        sdo;
        logic                        sdo_oe;
        logic [MONITOR_FIELD_W-1:0]  monitor_ctrl;
        logic [7:0]                  gate_ctrl;
        logic [7:0]                  detect_ctrl;
        logic                        gain_select;
        logic [1:0]                  sense_pos_sel;
        logic                        sense_neg_ground;
        logic [1:0]                  monitor_sel;
        logic                        charger_pullup;
        logic                        interrupt_out_n;
    } state_t;

endpackage

//--- afe_current_fet_charger_regs.sv
// Register bank for current monitor, gate drivers and charger detect.
// Assumes SPI mode 0 pins sampled directly; sck far slower than clk.
`timescale 1ns/10ps

module afe_current_fet_charger_regs
    import afe_regs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic       sdi,
    input  wire logic       short_detect,
    input  wire logic       low_cmp_in,
    input  wire logic       high_cmp_in,
    output logic            sdo,
    output logic            sdo_oe,
    output logic            gain_select,
    output logic [1:0]      sense_pos_sel,
    output logic            sense_neg_ground,
    output logic [1:0]      monitor_sel,
    output logic            discharge_gate,
    output logic            charge_gate,
    output logic            drive_boost,
    output logic            low_cmp_run,
    output logic            high_cmp_run,
    output logic            charger_pullup_enable,
    output logic            interrupt_out_n
);
    import afe_regs_pkg::*;

    state_t s;
    state_t next_s;

    // ========================================
    // Read mux
    function automatic logic [7:0] read_data(input state_t st,
                                             input logic [6:0] a);
        logic [7:0] d;
        d = 8'h00;
        if (a == OFF_CURRENT_MONITOR)
            d = {3'h0, st.monitor_ctrl};
        else if (a == OFF_GATE_DRIVER)
            d = st.gate_ctrl;
        else if (a == OFF_CHARGER_DETECT)
            d = st.detect_ctrl;
        return d;
    endfunction

    // ========================================
    // Next state
    always_comb
    begin
        logic       rise;
        logic       fall;
        logic       wr;
        logic [7:0] wdata;
        logic       zero_cal;
        logic       cal_in;
        logic       cal_out;
        logic [7:0] dc;

        next_s = s;
        rise = 1'b0;
        fall = 1'b0;
        wr = 1'b0;
        wdata = 8'h00;
        zero_cal = 1'b0;
        cal_in = 1'b0;
        cal_out = 1'b0;
        dc = 8'h00;

        next_s.sck_q = sck;
        rise = sck & ~s.sck_q;
        fall = ~sck & s.sck_q;

        // Serial frame: rw bit, 7 address bits, 8 data bits, MSB first
        if (cs_n)
        begin
            next_s.spi_state = SPI_IDLE;
            next_s.bit_cnt = 3'h0;
            next_s.sdo = 1'b0;
            next_s.sdo_oe = 1'b0;
        end
        else
        begin
            case (s.spi_state)
                SPI_IDLE:
                begin
                    next_s.spi_state = SPI_ADDR;
                end
                SPI_ADDR:
                begin
                    if (rise)
                    begin
                        next_s.shift = {s.shift[6:0], sdi};
                        next_s.bit_cnt = s.bit_cnt + 3'h1;
                        if (s.bit_cnt == LAST_BIT)
                        begin
                            next_s.rw = s.shift[6];
                            next_s.addr = {s.shift[5:0], sdi};
                            next_s.tx = read_data(s, {s.shift[5:0], sdi});
                            next_s.sdo_oe = s.shift[6];
                            next_s.spi_state = SPI_DATA;
                        end
                    end
                end
                SPI_DATA:
                begin
                    // Mode 0: drive on falling edge, host samples rising
                    if (fall && s.rw)
                    begin
                        next_s.sdo = s.tx[7];
                        next_s.tx = {s.tx[6:0], 1'b0};
                    end
                    if (rise)
                    begin
                        next_s.shift = {s.shift[6:0], sdi};
                        next_s.bit_cnt = s.bit_cnt + 3'h1;
                        if (s.bit_cnt == LAST_BIT)
                        begin
                            wr = ~s.rw;
                            wdata = {s.shift[6:0], sdi};
                            next_s.spi_state = SPI_DONE;
                        end
                    end
                end
                default:
                begin
                    // Extra clocks past one frame are ignored
                    next_s.spi_state = SPI_DONE;
                end
            endcase
        end

        // ========================================
        // Current monitor control
        if (wr && s.addr == OFF_CURRENT_MONITOR)
            next_s.monitor_ctrl = wdata[MONITOR_FIELD_W-1:0];

        zero_cal = next_s.monitor_ctrl[ZERO_CAL_BIT];
        cal_in = ~zero_cal & next_s.monitor_ctrl[GAIN_CAL_INPUT_BIT];
        cal_out = ~zero_cal & next_s.monitor_ctrl[GAIN_CAL_OUTPUT_BIT];
        next_s.gain_select = next_s.monitor_ctrl[GAIN_SELECT_BIT];

        if (zero_cal)
            next_s.sense_pos_sel = POS_GROUND;
        else if (cal_in)
            next_s.sense_pos_sel = next_s.gain_select ?
                                   POS_REF_20MV : POS_REF_100MV;
        else
            next_s.sense_pos_sel = POS_FROM_PIN;
        next_s.sense_neg_ground = zero_cal | cal_in;

        if (!next_s.monitor_ctrl[MONITOR_ENABLE_BIT])
            next_s.monitor_sel = MON_ZERO_VOLT;
        else if (cal_in && cal_out)
            next_s.monitor_sel = MON_REFERENCE;
        else
            next_s.monitor_sel = MON_AMPLIFIED;

        // ========================================
        // Gate driver control
        if (wr && s.addr == OFF_GATE_DRIVER)
        begin
            next_s.gate_ctrl = 8'h00;
            next_s.gate_ctrl[DISCHARGE_GATE_BIT] =
                wdata[DISCHARGE_GATE_BIT];
            next_s.gate_ctrl[CHARGE_GATE_BIT] = wdata[CHARGE_GATE_BIT];
            next_s.gate_ctrl[DRIVE_BOOST_BIT] = wdata[DRIVE_BOOST_BIT];
        end
        // Short wins over a host write in the same cycle; monitor bits
        // play no part here
        if (short_detect)
        begin
            next_s.gate_ctrl[DISCHARGE_GATE_BIT] = 1'b0;
            next_s.gate_ctrl[CHARGE_GATE_BIT] = 1'b0;
        end

        // ========================================
        // Charger detect control
        dc = s.detect_ctrl;
        if (wr && s.addr == OFF_CHARGER_DETECT)
        begin
            dc[LOW_RUN_BIT] = wdata[LOW_RUN_BIT];
            dc[LOW_IRQ_ENABLE_BIT] = wdata[LOW_IRQ_ENABLE_BIT];
            dc[HIGH_RUN_BIT] = wdata[HIGH_RUN_BIT];
            dc[HIGH_IRQ_ENABLE_BIT] = wdata[HIGH_IRQ_ENABLE_BIT];
            if (!wdata[LOW_FLAG_BIT])
                dc[LOW_FLAG_BIT] = 1'b0;
            if (!wdata[HIGH_FLAG_BIT])
                dc[HIGH_FLAG_BIT] = 1'b0;
        end
        dc[LOW_STATUS_BIT] = dc[LOW_RUN_BIT] & low_cmp_in;
        dc[HIGH_STATUS_BIT] = dc[HIGH_RUN_BIT] & high_cmp_in;
        // Set after clear so an edge in a clearing cycle is kept
        if (dc[LOW_IRQ_ENABLE_BIT] && dc[LOW_STATUS_BIT]
            && !s.detect_ctrl[LOW_STATUS_BIT])
            dc[LOW_FLAG_BIT] = 1'b1;
        if (dc[HIGH_IRQ_ENABLE_BIT] && dc[HIGH_STATUS_BIT]
            && !s.detect_ctrl[HIGH_STATUS_BIT])
            dc[HIGH_FLAG_BIT] = 1'b1;
        if (!dc[LOW_IRQ_ENABLE_BIT])
            dc[LOW_FLAG_BIT] = 1'b0;
        if (!dc[HIGH_IRQ_ENABLE_BIT])
            dc[HIGH_FLAG_BIT] = 1'b0;
        next_s.detect_ctrl = dc;

        // Pull-up shared by both comparators on the one sense pin
        next_s.charger_pullup = dc[LOW_RUN_BIT] | dc[HIGH_RUN_BIT];

        next_s.interrupt_out_n =
            ~(dc[LOW_FLAG_BIT] | dc[HIGH_FLAG_BIT]);
    end

    // ========================================
    // State register
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            s <= '0;
            s.monitor_ctrl <= RST_CURRENT_MONITOR[MONITOR_FIELD_W-1:0];
            s.gate_ctrl <= RST_GATE_DRIVER;
            s.detect_ctrl <= RST_CHARGER_DETECT;
            s.interrupt_out_n <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ========================================
    // Outputs, all straight from the state register
    assign sdo                   = s.sdo;
    assign sdo_oe                = s.sdo_oe;
    assign gain_select           = s.gain_select;
    assign sense_pos_sel         = s.sense_pos_sel;
    assign sense_neg_ground      = s.sense_neg_ground;
    assign monitor_sel           = s.monitor_sel;
    assign discharge_gate        = s.gate_ctrl[DISCHARGE_GATE_BIT];
    assign charge_gate           = s.gate_ctrl[CHARGE_GATE_BIT];
    assign drive_boost           = s.gate_ctrl[DRIVE_BOOST_BIT];
    assign low_cmp_run           = s.detect_ctrl[LOW_RUN_BIT];
    assign high_cmp_run          = s.detect_ctrl[HIGH_RUN_BIT];
    assign charger_pullup_enable = s.charger_pullup;
    assign interrupt_out_n       = s.interrupt_out_n;

endmodule // afe_current_fet_charger_regs

//--- afe_regs_assertions.sv
// Port checker for the front-end register block.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/10ps

module afe_regs_checker
    import afe_regs_pkg::*;
(
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       cs_n,
    input wire logic       short_detect,
    input wire logic       low_cmp_in,
    input wire logic       high_cmp_in,
    input wire logic       sdo,
    input wire logic       sdo_oe,
    input wire logic       gain_select,
    input wire logic [1:0] sense_pos_sel,
    input wire logic       sense_neg_ground,
    input wire logic [1:0] monitor_sel,
    input wire logic       discharge_gate,
    input wire logic       charge_gate,
    input wire logic       low_cmp_run,
    input wire logic       high_cmp_run,
    input wire logic       charger_pullup_enable,
    input wire logic       interrupt_out_n
);
    // ========
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    logic cmp_hit;
    assign cmp_hit = (low_cmp_run && low_cmp_in)
                  || (high_cmp_run && high_cmp_in);

    sequence s_gates_off;
        !discharge_gate && !charge_gate;
    endsequence

    chk_zero_grounds: assert property (
        sense_pos_sel == POS_GROUND |-> sense_neg_ground)
        else $error("zero calibration left negative input open");
    chk_zero_no_ref: assert property (
        sense_pos_sel == POS_GROUND |-> monitor_sel != MON_REFERENCE)
        else $error("reference output during zero calibration");
    chk_cal_ref_gain: assert property (
        sense_pos_sel[1] |-> sense_neg_ground
            && gain_select == sense_pos_sel[0])
        else $error("calibration reference does not match gain");
    chk_ref_needs_cal: assert property (
        monitor_sel == MON_REFERENCE |-> sense_pos_sel[1])
        else $error("reference output without input calibration");
    chk_short_clears: assert property (
        short_detect |=> s_gates_off)
        else $error("gate stayed on during short");
    chk_pullup_or: assert property (
        charger_pullup_enable == (low_cmp_run || high_cmp_run))
        else $error("pull-up does not follow comparator run bits");
    chk_irq_cause: assert property (
        $fell(interrupt_out_n) |-> $past(cmp_hit))
        else $error("interrupt without comparator rise");
    chk_sdo_release: assert property (
        cs_n |=> !sdo_oe && !sdo)
        else $error("data out still driven after deselect");
    chk_sdo_gated: assert property (
        sdo |-> sdo_oe)
        else $error("data out shown without output enable");
endmodule // afe_regs_checker

bind afe_current_fet_charger_regs afe_regs_checker u_chk (
    .clk(clk), .resetn(resetn), .cs_n(cs_n),
    .short_detect(short_detect), .low_cmp_in(low_cmp_in),
    .high_cmp_in(high_cmp_in), .sdo(sdo), .sdo_oe(sdo_oe),
    .gain_select(gain_select), .sense_pos_sel(sense_pos_sel),
    .sense_neg_ground(sense_neg_ground), .monitor_sel(monitor_sel),
    .discharge_gate(discharge_gate), .charge_gate(charge_gate),
    .low_cmp_run(low_cmp_run), .high_cmp_run(high_cmp_run),
    .charger_pullup_enable(charger_pullup_enable),
    .interrupt_out_n(interrupt_out_n)
);

//--- spi_host_model.sv
// Host controller model speaking SPI mode 0 to the register block.
// Assumes tasks are called from a process synchronous to clk.
`timescale 1ns/10ps

module spi_host_model
(
    input  wire logic clk,
    input  wire logic sdo,
    output logic      cs_n,
    output logic      sck,
    output logic      sdi
);
    // ========
    // Frame engine
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end

    // Three cycles per phase keeps sck well above the two-cycle minimum
    task automatic half();
        repeat (3) @(negedge clk);
    endtask

    task automatic xfer(input logic rw, input logic [6:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {rw, a, d};
        q = 8'h00;
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            sdi = f[i];
            half();
            sck = 1'b1;
            if (i < 8)
                q = {q[6:0], sdo};
            half();
            sck = 1'b0;
        end
        half();
        cs_n = 1'b1;
        // Released line must not keep showing the last bit
        sdi = ~sdi;
        half();
    endtask
endmodule // spi_host_model

//--- afe_current_fet_charger_regs_test.sv
// Self-checking bench for the front-end register block.
// Assumes the SPI host model and the bound port checker.
`timescale 1ns/10ps

module afe_current_fet_charger_regs_test;
    import afe_regs_pkg::*;

    logic       clk = 1'b0;
    logic       resetn, short_detect, low_cmp_in, high_cmp_in;
    logic       cs_n, sck, sdi, sdo, sdo_oe, gain_select;
    logic [1:0] sense_pos_sel, monitor_sel;
    logic       sense_neg_ground, discharge_gate, charge_gate;
    logic       drive_boost, low_cmp_run, high_cmp_run;
    logic       charger_pullup_enable, interrupt_out_n;
    logic [7:0] mon, gates, runs;
    int         failures = 0;
    int         tests_run = 0;

    assign mon = {2'b00, gain_select, sense_pos_sel, sense_neg_ground,
                  monitor_sel};
    assign gates = {5'h00, drive_boost, charge_gate, discharge_gate};
    assign runs = {6'h00, high_cmp_run, low_cmp_run};

    always #2 clk = ~clk;

    afe_current_fet_charger_regs u_dut (
        .clk(clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .sdi(sdi),
        .short_detect(short_detect), .low_cmp_in(low_cmp_in),
        .high_cmp_in(high_cmp_in), .sdo(sdo), .sdo_oe(sdo_oe),
        .gain_select(gain_select), .sense_pos_sel(sense_pos_sel),
        .sense_neg_ground(sense_neg_ground), .monitor_sel(monitor_sel),
        .discharge_gate(discharge_gate), .charge_gate(charge_gate),
        .drive_boost(drive_boost), .low_cmp_run(low_cmp_run),
        .high_cmp_run(high_cmp_run),
        .charger_pullup_enable(charger_pullup_enable),
        .interrupt_out_n(interrupt_out_n)
    );

    spi_host_model u_host (
        .clk(clk), .sdo(sdo), .cs_n(cs_n), .sck(sck), .sdi(sdi)
    );

    // ========
    // Helpers
    task automatic check(input string n, input logic [7:0] e,
                         input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_host.xfer(1'b0, a, d, q);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_host.xfer(1'b1, a, 8'h00, q);
        check($sformatf("register %h", a), e, q);
    endtask

    task automatic set_pin(input int s, input logic v);
        @(negedge clk);
        if (s == 0)
            low_cmp_in = v;
        else
            high_cmp_in = v;
        repeat (3) @(negedge clk);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ========
    // Scenarios
    task automatic t_reset();
        check("interrupt_out_n", 8'h01, {7'h00, interrupt_out_n});
        check("gate pins", 8'h00, gates);
        rd(OFF_CURRENT_MONITOR, RST_CURRENT_MONITOR);
        rd(OFF_GATE_DRIVER, RST_GATE_DRIVER);
        rd(OFF_CHARGER_DETECT, RST_CHARGER_DETECT);
        wr(7'h05, 8'hFF);
        rd(7'h05, 8'h00);
    endtask

    task automatic t_monitor();
        logic [7:0] d [9];
        logic [5:0] x [9];
        d = '{8'h00, 8'h10, 8'h14, 8'h15, 8'h18, 8'h1C, 8'h1E, 8'h0C,
              8'hFF};
        x = '{6'h00, 6'h01, 6'h15, 6'h3D, 6'h01, 6'h16, 6'h0D, 6'h14,
              6'h2D};
        foreach (d[i])
        begin
            wr(OFF_CURRENT_MONITOR, d[i]);
            check("monitor pins", {2'b00, x[i]}, mon);
            rd(OFF_CURRENT_MONITOR, d[i] & 8'h1F);
        end
    endtask

    task automatic t_gates();
        wr(OFF_GATE_DRIVER, 8'hFF);
        check("gate pins", 8'h07, gates);
        rd(OFF_GATE_DRIVER, 8'h13);
        @(negedge clk);
        short_detect = 1'b1;
        repeat (4) @(negedge clk);
        short_detect = 1'b0;
        repeat (4) @(negedge clk);
        check("gate pins", 8'h04, gates);
        rd(OFF_GATE_DRIVER, 8'h10);
        wr(OFF_GATE_DRIVER, 8'h03);
        check("gate pins", 8'h03, gates);
    endtask

    task automatic t_cmp(input int s);
        set_pin(s, 1'b1);
        rd(OFF_CHARGER_DETECT, 8'h00);
        wr(OFF_CHARGER_DETECT, 8'h08 << s);
        check("pull-up", 8'h01, {7'h00, charger_pullup_enable});
        check("run pins", 8'h01 << (s / 4), runs);
        rd(OFF_CHARGER_DETECT, 8'h09 << s);
        set_pin(s, 1'b0);
        // No 1 ms settle wait: the modelled comparator input is ideal
        wr(OFF_CHARGER_DETECT, 8'h0C << s);
        set_pin(s, 1'b1);
        check("interrupt_out_n", 8'h00, {7'h00, interrupt_out_n});
        rd(OFF_CHARGER_DETECT, 8'h0F << s);
        wr(OFF_CHARGER_DETECT, 8'h0D << s);
        rd(OFF_CHARGER_DETECT, 8'h0D << s);
        check("interrupt_out_n", 8'h01, {7'h00, interrupt_out_n});
        wr(OFF_CHARGER_DETECT, 8'h0E << s);
        rd(OFF_CHARGER_DETECT, 8'h0D << s);
        set_pin(s, 1'b0);
        set_pin(s, 1'b1);
        check("interrupt_out_n", 8'h00, {7'h00, interrupt_out_n});
        wr(OFF_CHARGER_DETECT, 8'h08 << s);
        rd(OFF_CHARGER_DETECT, 8'h09 << s);
        check("interrupt_out_n", 8'h01, {7'h00, interrupt_out_n});
        wr(OFF_CHARGER_DETECT, 8'h00);
        check("pull-up", 8'h00, {7'h00, charger_pullup_enable});
        check("run pins", 8'h00, runs);
    endtask

    task automatic t_midreset();
        wr(OFF_GATE_DRIVER, 8'h13);
        @(negedge clk);
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        check("gate pins", 8'h00, gates);
        check("interrupt_out_n", 8'h01, {7'h00, interrupt_out_n});
        rd(OFF_GATE_DRIVER, RST_GATE_DRIVER);
    endtask

    initial
    begin
        resetn = 1'b0;
        short_detect = 1'b0;
        low_cmp_in = 1'b0;
        high_cmp_in = 1'b0;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        t_reset();
        t_monitor();
        t_gates();
        t_cmp(0);
        t_cmp(4);
        t_midreset();
        complete_run();
    end

    // Whole run needs about 5500 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        complete_run();
    end
endmodule // afe_current_fet_charger_regs_test
